// ===== ldirx_pkg.sv
/*
 * Package for the disabled / inactive / receiver-detect link state logic.
 * Assumes a 100 MHz system clock; holds register map, states and timing constants.
 */
package ldirx_pkg;

	// ****************************************************************
	// Clock and timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS          = 10;
	localparam int INACTIVE_QUIET_MS      = 12;
	localparam int UP_DETECT_QUIET_MS     = 12;
	localparam int DOWN_DETECT_QUIET_MS   = 12;
	localparam int INACTIVE_QUIET_CYC     = INACTIVE_QUIET_MS * 1000000 / CLK_PERIOD_NS;
	localparam int UP_DETECT_QUIET_CYC    = UP_DETECT_QUIET_MS * 1000000 / CLK_PERIOD_NS;
	localparam int DOWN_DETECT_QUIET_CYC  = DOWN_DETECT_QUIET_MS * 1000000 / CLK_PERIOD_NS;
	localparam int TIMER_W                = 24;

	// ****************************************************************
	// Counters
	// ****************************************************************
	localparam logic [1:0] DIS_CNT_RST    = 2'h0;
	localparam logic [1:0] DIS_CNT_LIMIT  = 2'h3;
	localparam logic [3:0] DET_CNT_RST    = 4'h0;
	localparam logic [3:0] DET_CNT_LIMIT  = 4'h8;

	// ****************************************************************
	// Port roles
	// ****************************************************************
	localparam logic [1:0] ROLE_DOWN      = 2'h0;
	localparam logic [1:0] ROLE_HUB_UP    = 2'h1;
	localparam logic [1:0] ROLE_PERIPH_UP = 2'h2;

	// ****************************************************************
	// Register map (byte offsets)
	// ****************************************************************
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_STATUS     = 8'h04;
	localparam logic [7:0] REG_COUNT      = 8'h08;
	localparam logic [31:0] CTRL_RST      = 32'h0000_0000;

	// CTRL bit positions
	localparam int CTRL_ROLE_LSB          = 0;
	localparam int CTRL_SELF_POWERED      = 2;
	localparam int CTRL_DIRECT_DISABLE    = 3;
	localparam int CTRL_DIRECT_RXDET      = 4;
	localparam int CTRL_ISSUE_WARM        = 5;

	typedef enum logic [3:0] {
		LDIRX_DISABLED,
		LDIRX_DIS_DEFAULT,
		LDIRX_DIS_ERROR,
		LDIRX_INACT_QUIET,
		LDIRX_INACT_DISC_DET,
		LDIRX_RXD_RESET,
		LDIRX_RXD_ACTIVE,
		LDIRX_RXD_QUIET,
		LDIRX_POLLING,
		LDIRX_OTHER
	} ldirx_state_t;

	// AXI responses
	localparam logic [1:0] AXI_OKAY       = 2'h0;
	localparam logic [1:0] AXI_SLVERR     = 2'h2;

endpackage

// ===== ldirx_timer.sv
/*
 * Down-counting timer: load on start, one-cycle done pulse on expiry.
 * Assumes start is a single-cycle pulse from the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ldirx_timer
	import ldirx_pkg::*;
(
	// Clock and reset
	input  wire logic               i_clk,
	input  wire logic               i_sys_rst,
	// Control
	input  wire logic               i_start,
	input  wire logic               i_stop,
	input  wire logic [TIMER_W-1:0] i_load,
	// Status
	output logic                    o_done
);
	logic [TIMER_W-1:0] count;
	logic               running;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_stop) begin
			count   <= '0;
			running <= 1'b0;
			o_done  <= 1'b0;
		end else if (i_start) begin
			count   <= i_load;
			running <= 1'b1;
			o_done  <= 1'b0;
		end else if (running && count <= TIMER_W'(1)) begin
			running <= 1'b0;
			o_done  <= 1'b1;
		end else begin
			count  <= running ? count - TIMER_W'(1) : count;
			o_done <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== ldirx_sync.sv
/*
 * Two flip-flop synchroniser for one asynchronous level.
 * Assumes the source holds each level for more than two clocks.
 */
`timescale 1ns/1ps
`default_nettype none
module ldirx_sync
	import ldirx_pkg::*;
(
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	// Level
	input  wire logic i_async,
	output logic      o_sync
);
	logic meta;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			meta   <= 1'b0;
			o_sync <= 1'b0;
		end else begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end
endmodule
`default_nettype wire

// ===== ldirx_fsm.sv
/*
 * Link state logic for disabled, inactive and receiver-detect states,
 * with an AXI4-Lite register slave.
 * Assumes VBUS and USB 2.0 reset arrive asynchronously; the analog
 * detection front end answers by a request/done handshake on i_clk.
 */
// What this block does
// RULE1: Downstream port enters disabled from any state when directed.
// RULE2: Self-powered upstream port enters disabled when VBUS invalid.
// RULE3: Disabled requests high impedance termination, no LFPS or signalling.
// RULE4: Downstream port leaves disabled to receiver detect only when directed.
// RULE5: Hub upstream leaves disabled on VBUS going valid or bus reset.
// RULE6: Peripheral entry counter clears on invalid VBUS or configuration success.
// RULE7: Entry counter increments on each entry to disabled default.
// RULE8: Default goes to receiver detect on VBUS valid or reset with count<3.
// RULE9: Default goes to disabled error when counter equals 3.
// RULE10: Error leaves to receiver detect only on power-on reset.
// RULE11: Self-powered error returns to default on invalid VBUS.
// RULE12: Error ignores USB 2.0 bus resets.
// RULE13: Inactive quiet entry disables detection and starts 12 ms timer.
// RULE14: Inactive quiet timer expiry moves to disconnect detect.
// RULE15: Downstream inactive quiet goes disabled when directed.
// RULE16: Downstream inactive quiet goes receiver detect on issuing warm reset.
// RULE17: Upstream inactive quiet goes receiver detect on detected warm reset.
// RULE18: Disconnect detect runs detection; no termination goes receiver detect.
// RULE19: Disconnect detect finding termination returns to inactive quiet.
// RULE20: Receiver detect follows power-on and warm reset outside disabled.
// RULE21: Receiver detect reset substate exits at once without warm reset.
// RULE22: Low impedance termination requested throughout receiver detect.
// RULE23: Receiver detect quiet times 12 ms then moves to active.
// RULE24: Peripheral counts detections; eight with none found goes disabled.
// RULE25: Two-bit saturating entry counter; timers from parameterised cycle counts.
`timescale 1ns/1ps
`default_nettype none
module ldirx_fsm
	import ldirx_pkg::*;
#(
	parameter int INACT_CYC = INACTIVE_QUIET_CYC,
	parameter int UP_CYC    = UP_DETECT_QUIET_CYC,
	parameter int DOWN_CYC  = DOWN_DETECT_QUIET_CYC
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Asynchronous pin levels
	input  wire logic        i_vbus_valid,
	input  wire logic        i_usb2_bus_reset,
	// Link side events, same clock
	input  wire logic        i_warm_reset_detected,
	input  wire logic        i_warm_reset_done,
	input  wire logic        i_config_success,
	input  wire logic        i_enter_inactive,
	input  wire logic        i_polling_exit_rxdet,
	input  wire logic        i_det_done,
	input  wire logic        i_det_found,
	// Front end controls
	output logic             o_det_req,
	output logic             o_term_low_imp,
	output logic             o_lfps_enable,
	output logic             o_warm_reset_tx,
	output logic [3:0]       o_state
);

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [2:0]   ctrl;
	ldirx_state_t state;
	logic [1:0]   disabled_entry_counter;
	logic [3:0]   det_count;
	logic         vbus_s;
	logic         vbus_q;
	logic         breset_s;
	logic         breset_q;
	logic         det_pending;
	logic         warm_entry;
	logic         aw_hold;
	logic         w_hold;
	logic [7:0]   aw_addr;
	logic [31:0]  w_data;
	logic [3:0]   w_strb;
	logic         inact_done;
	logic         rxq_done;
	logic         cmd_disable;
	logic         cmd_rxdet;
	logic         cmd_warm;
	ldirx_state_t next_state;
	ldirx_state_t dis_target;

	wire logic [1:0] role         = ctrl[CTRL_ROLE_LSB +: 2];
	wire logic       self_powered = ctrl[CTRL_SELF_POWERED];
	wire logic       is_down      = (role == ROLE_DOWN);
	wire logic       is_periph    = (role == ROLE_PERIPH_UP);
	wire logic       vbus_rise    = vbus_s && !vbus_q;
	wire logic       vbus_fall    = !vbus_s && vbus_q;
	wire logic       breset_rise  = breset_s && !breset_q;

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	ldirx_sync u_sync_vbus (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_async   (i_vbus_valid),
		.o_sync    (vbus_s)
	);

	ldirx_sync u_sync_breset (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_async   (i_usb2_bus_reset),
		.o_sync    (breset_s)
	);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			vbus_q   <= 1'b0;
			breset_q <= 1'b0;
		end else begin
			vbus_q   <= vbus_s;
			breset_q <= breset_s;
		end
	end

	// ****************************************************************
	// Timers
	// ****************************************************************
	// RULE13: start quiet timer
	wire logic inact_start = (state != LDIRX_INACT_QUIET) && (next_state == LDIRX_INACT_QUIET);
	wire logic rxq_start   = (state != LDIRX_RXD_QUIET) && (next_state == LDIRX_RXD_QUIET);

	ldirx_timer u_inact_timer (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_start   (inact_start),
		.i_stop    (state != LDIRX_INACT_QUIET && !inact_start),
		.i_load    (TIMER_W'(INACT_CYC)),
		.o_done    (inact_done)
	);

	// RULE23: role-dependent quiet time
	ldirx_timer u_rxq_timer (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_start   (rxq_start),
		.i_stop    (state != LDIRX_RXD_QUIET && !rxq_start),
		.i_load    (is_down ? TIMER_W'(DOWN_CYC) : TIMER_W'(UP_CYC)),
		.o_done    (rxq_done)
	);

	// ****************************************************************
	// State machine
	// ****************************************************************
	always_comb begin
		dis_target = is_periph ? LDIRX_DIS_DEFAULT : LDIRX_DISABLED;
		next_state = state;
		unique case (state)
			LDIRX_DISABLED: begin
				// RULE4: downstream exit on direction only
				if (is_down && cmd_rxdet) begin
					next_state = LDIRX_RXD_RESET;
				// RULE5: hub upstream exit
				end else if (!is_down && (vbus_rise || breset_rise)) begin
					next_state = LDIRX_RXD_RESET;
				end
			end
			LDIRX_DIS_DEFAULT: begin
				// RULE9: limit reached
				if (disabled_entry_counter == DIS_CNT_LIMIT) begin
					next_state = LDIRX_DIS_ERROR;
				// RULE8: retry on VBUS or bus reset
				end else if (vbus_rise || breset_rise) begin
					next_state = LDIRX_RXD_RESET;
				end
			end
			LDIRX_DIS_ERROR: begin
				// RULE11: back to default; RULE10 RULE12: bus reset ignored
				if (self_powered && vbus_fall) begin
					next_state = LDIRX_DIS_DEFAULT;
				end
			end
			LDIRX_INACT_QUIET: begin
				// RULE16: warm reset issued
				if (is_down && cmd_warm) begin
					next_state = LDIRX_RXD_RESET;
				// RULE17: warm reset seen
				end else if (!is_down && i_warm_reset_detected) begin
					next_state = LDIRX_RXD_RESET;
				// RULE14: timer expiry
				end else if (inact_done) begin
					next_state = LDIRX_INACT_DISC_DET;
				end
			end
			LDIRX_INACT_DISC_DET: begin
				// RULE18 RULE19: detection outcome
				if (i_det_done) begin
					next_state = i_det_found ? LDIRX_INACT_QUIET : LDIRX_RXD_RESET;
				end
			end
			LDIRX_RXD_RESET: begin
				// RULE21: immediate exit when no warm reset
				if (!warm_entry || i_warm_reset_done) begin
					next_state = LDIRX_RXD_ACTIVE;
				end
			end
			LDIRX_RXD_ACTIVE: begin
				if (i_det_done) begin
					if (i_det_found) begin
						next_state = LDIRX_POLLING;
					// RULE24: eighth failed detection
					end else if (is_periph && det_count + 4'h1 >= DET_CNT_LIMIT) begin
						next_state = dis_target;
					end else begin
						next_state = LDIRX_RXD_QUIET;
					end
				end
			end
			LDIRX_RXD_QUIET: begin
				if (rxq_done) begin
					next_state = LDIRX_RXD_ACTIVE;
				end
			end
			LDIRX_POLLING: begin
				if (i_polling_exit_rxdet) begin
					next_state = LDIRX_RXD_RESET;
				end else if (i_enter_inactive) begin
					next_state = LDIRX_INACT_QUIET;
				end
			end
			default: begin
				next_state = LDIRX_RXD_RESET;
			end
		endcase
		// RULE20: warm reset outside disabled enters receiver detect
		if (state != LDIRX_DISABLED && state != LDIRX_DIS_DEFAULT && state != LDIRX_DIS_ERROR
		    && state != LDIRX_RXD_RESET) begin
			if ((is_down && cmd_warm) || (!is_down && i_warm_reset_detected)) begin
				next_state = LDIRX_RXD_RESET;
			end
		end
		// RULE2: self-powered upstream loses VBUS
		if (!is_down && self_powered && !vbus_s && state != LDIRX_DIS_ERROR) begin
			next_state = dis_target;
		end
		// RULE1 RULE15: directed disable
		if (is_down && cmd_disable) begin
			next_state = LDIRX_DISABLED;
		end
	end

	// RULE20: power-on enters receiver detect
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state <= LDIRX_RXD_RESET;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			warm_entry <= 1'b0;
		end else if (next_state == LDIRX_RXD_RESET && state != LDIRX_RXD_RESET) begin
			warm_entry <= (is_down && cmd_warm) || (!is_down && i_warm_reset_detected);
		end else if (state == LDIRX_RXD_RESET && i_warm_reset_done) begin
			warm_entry <= 1'b0;
		end
	end

	// RULE7: count entries; RULE6: clears win; RULE25: saturate at 3
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || (is_periph && (!vbus_s || i_config_success))) begin
			disabled_entry_counter <= DIS_CNT_RST;
		end else if (next_state == LDIRX_DIS_DEFAULT && state != LDIRX_DIS_DEFAULT
		             && disabled_entry_counter != DIS_CNT_LIMIT) begin
			disabled_entry_counter <= disabled_entry_counter + 2'h1;
		end
	end

	// RULE24: detection event count
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || state == LDIRX_POLLING || state == LDIRX_DISABLED
		    || state == LDIRX_DIS_DEFAULT) begin
			det_count <= DET_CNT_RST;
		end else if (state == LDIRX_RXD_ACTIVE && i_det_done && det_count != DET_CNT_LIMIT) begin
			det_count <= det_count + 4'h1;
		end
	end

	// ****************************************************************
	// Front end outputs
	// ****************************************************************
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			det_pending <= 1'b0;
		end else begin
			det_pending <= (next_state == LDIRX_RXD_ACTIVE || next_state == LDIRX_INACT_DISC_DET)
			               && !(i_det_done && state == next_state);
		end
	end

	wire logic in_disabled = (state == LDIRX_DISABLED || state == LDIRX_DIS_DEFAULT
	                          || state == LDIRX_DIS_ERROR);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_term_low_imp  <= 1'b0;
			o_lfps_enable   <= 1'b0;
			o_warm_reset_tx <= 1'b0;
			o_state         <= 4'h0;
		end else begin
			// RULE3 RULE22: termination request
			o_term_low_imp  <= !in_disabled;
			o_lfps_enable   <= !in_disabled && state != LDIRX_RXD_RESET;
			o_warm_reset_tx <= is_down && state == LDIRX_RXD_RESET && warm_entry;
			o_state         <= 4'(state);
		end
	end

	// RULE13 RULE18: detection only in active substates
	assign o_det_req = det_pending;

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	assign s_axi_awready = !aw_hold && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	wire logic wr_go = aw_hold && w_hold;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			aw_hold <= 1'b0;
			w_hold  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_hold <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go) begin
				w_hold <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= AXI_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr == REG_CTRL) ? AXI_OKAY : AXI_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Command bits are one-cycle pulses; stored bits are role and power
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ctrl        <= CTRL_RST[2:0];
			cmd_disable <= 1'b0;
			cmd_rxdet   <= 1'b0;
			cmd_warm    <= 1'b0;
		end else begin
			cmd_disable <= 1'b0;
			cmd_rxdet   <= 1'b0;
			cmd_warm    <= 1'b0;
			if (wr_go && aw_addr == REG_CTRL && w_strb[0]) begin
				ctrl[2:0]   <= w_data[2:0];
				cmd_disable <= w_data[CTRL_DIRECT_DISABLE];
				cmd_rxdet   <= w_data[CTRL_DIRECT_RXDET];
				cmd_warm    <= w_data[CTRL_ISSUE_WARM];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= AXI_OKAY;
			unique case (s_axi_araddr)
				REG_CTRL:   s_axi_rdata <= {29'h0, ctrl[2:0]};
				REG_STATUS: s_axi_rdata <= {26'h0, vbus_s, o_term_low_imp, 4'(state)};
				REG_COUNT:  s_axi_rdata <= {26'h0, det_count, disabled_entry_counter};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= AXI_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ===== ldirx_fsm_asserts.sv
/* Checker for ldirx_fsm: timing and pin relations of the link states.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module ldirx_fsm_asserts
	import ldirx_pkg::*;
#(
	parameter int INACT_CYC = INACTIVE_QUIET_CYC
) (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	// Observed pins
	input  wire logic       i_vbus_valid,
	input  wire logic       i_det_done,
	input  wire logic       i_det_found,
	input  wire logic       o_det_req,
	input  wire logic       o_term_low_imp,
	input  wire logic       o_lfps_enable,
	input  wire logic [3:0] o_state
);
	// ****************************************************************
	// Helpers and properties
	// ****************************************************************
	logic [23:0] quiet_cycles;
	logic        dis_now;
	logic        rxd_now;

	assign dis_now = o_state <= 4'h2;
	assign rxd_now = o_state == 4'h6 || o_state == 4'h7;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	// Counts edges spent in inactive quiet
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || o_state != 4'h3)
			quiet_cycles <= 24'h00_0000;
		else
			quiet_cycles <= quiet_cycles + 24'h00_0001;
	end

	a_disabled_pins_off: assert property (
		dis_now && $past(dis_now) |-> !o_term_low_imp && !o_lfps_enable && !o_det_req)
		else $error("Disabled port drives pins");
	a_rxdet_term_low: assert property (
		rxd_now && $past(rxd_now) |-> o_term_low_imp) else $error("Detect lost termination");
	a_power_on_detect: assert property (
		$fell(i_sys_rst) |-> ##[0:4] o_state == 4'h6) else $error("No detect after reset");
	a_quiet_exit_time: assert property (
		o_state == 4'h4 && $past(o_state) == 4'h3
		|-> quiet_cycles >= INACT_CYC - 2 && quiet_cycles <= INACT_CYC + 2)
		else $error("Quiet left early");
	a_quiet_bounded: assert property (
		quiet_cycles <= INACT_CYC + 3) else $error("Quiet timer stuck");
	a_quiet_no_det: assert property (
		o_state == 4'h3 && $past(o_state) == 4'h3 && $past(o_state, 2) == 4'h3
		|-> !$past(o_det_req)) else $error("Detection on in quiet");
	a_found_to_quiet: assert property (
		o_state == 4'h4 && o_det_req && i_det_done && i_det_found |-> ##2 o_state == 4'h3)
		else $error("Found did not return to quiet");
	a_none_to_detect: assert property (
		o_state == 4'h4 && o_det_req && i_det_done && !i_det_found
		|-> ##2 (o_state == 4'h5 || o_state == 4'h6)) else $error("Absent partner not detected");
	a_error_holds: assert property (
		o_state == 4'h2 && i_vbus_valid |=> o_state == 4'h2) else $error("Error state left");

	c_error: cover property (o_state == 4'h2);
	c_default: cover property (o_state == 4'h1);
	c_disc_detect: cover property (o_state == 4'h4);
endmodule
`default_nettype wire

// ===== ldirx_link_partner.sv
/* Far-end model: answers detection requests after a varying delay.
   Assumes the request is a level on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module ldirx_link_partner (
	// Clock
	input  wire logic       i_clk,
	// Request and control
	input  wire logic       i_det_req,
	input  wire logic       i_found,
	input  wire logic [2:0] i_delay,
	// Answer
	output logic            o_det_done,
	output logic            o_det_found
);
	// ****************************************************************
	// Answer logic
	// ****************************************************************
	logic [3:0] wait_cnt = 4'h0;

	initial begin
		o_det_done = 1'b0;
		o_det_found = 1'b0;
	end

	// Three settling cycles, so a lagging request is not answered twice
	always @(posedge i_clk) begin
		o_det_found <= ~o_det_found;
		o_det_done  <= 1'b0;
		wait_cnt    <= 4'h0;
		if (i_det_req && !o_det_done && wait_cnt < {1'b0, i_delay} + 4'h3)
			wait_cnt <= wait_cnt + 4'h1;
		else if (i_det_req && !o_det_done) begin
			o_det_done  <= 1'b1;
			o_det_found <= i_found;
		end
	end
endmodule
`default_nettype wire

// ===== ldirx_fsm_bench.sv
/* Bench for ldirx_fsm: register master, pin stimulus, far-end model.
   Assumes the package, design, checker and partner are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module ldirx_fsm_bench
	import ldirx_pkg::*;
;
	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	localparam int SHORT = 20;
	logic        i_clk = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        vbus = 1'b1, warm_det = 1'b0, found = 1'b0;
	logic [3:0]  evt = 4'h0; // Bus reset, warm done, config ok, enter inactive
	logic [2:0]  delay = 3'h0;
	logic        awready, wready, bvalid, arready, rvalid, det_req, det_done, det_found;
	logic        term, lfps, warm_tx;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rdata, rd;
	logic [3:0]  o_state;
	int          miscompares = 0, checks_done = 0, cycles = 0, k;

	ldirx_fsm #(.INACT_CYC(SHORT), .UP_CYC(SHORT), .DOWN_CYC(SHORT)) dut (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.i_vbus_valid(vbus), .i_usb2_bus_reset(evt[0]), .i_warm_reset_detected(warm_det),
		.i_warm_reset_done(evt[1]), .i_config_success(evt[2]),
		.i_enter_inactive(evt[3]), .i_polling_exit_rxdet(1'b0),
		.i_det_done(det_done), .i_det_found(det_found), .o_det_req(det_req),
		.o_term_low_imp(term), .o_lfps_enable(lfps), .o_warm_reset_tx(warm_tx),
		.o_state(o_state));

	ldirx_link_partner u_partner (.i_clk(i_clk), .i_det_req(det_req), .i_found(found),
		.i_delay(delay), .o_det_done(det_done), .o_det_found(det_found));

	// ****************************************************************
	// Clock, timeout and tasks
	// ****************************************************************
	always #5 i_clk = ~i_clk;

	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		delay <= 3'($urandom_range(7));
		if (cycles == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		if (miscompares == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge i_clk);
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		awvalid <= wr;
		wvalid <= wr;
		bready <= wr;
		arvalid <= !wr;
		rready <= !wr;
		do begin
			@(negedge i_clk);
			ta = wr ? awready : arready;
			tw = wready;
			tb = wr ? bvalid : rvalid;
			resp = wr ? bresp : rresp;
			rd = rdata;
			@(posedge i_clk);
			if (ta) begin
				awvalid <= 1'b0;
				arvalid <= 1'b0;
			end
			if (tw)
				wvalid <= 1'b0;
		end while (tb !== 1'b1);
		bready <= 1'b0;
		rready <= 1'b0;
	endtask

	task automatic wait_state(input logic [3:0] s);
		do
			@(negedge i_clk);
		while (o_state !== s);
		check({28'h0, o_state}, {28'h0, s});
		@(posedge i_clk);
	endtask

	task automatic pulse(input int idx, input int n);
		@(posedge i_clk);
		evt[idx] <= 1'b1;
		repeat (n) @(posedge i_clk);
		evt[idx] <= 1'b0;
	endtask

	task automatic to_quiet();
		found <= 1'b1;
		wait_state(4'h8);
		pulse(3, 1);
		wait_state(4'h3);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		void'($urandom(81));
		repeat (20) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		wait_state(4'h6);
		axi(1'b0, 8'h0c, 32'h0000_0000);
		check({30'h0, resp}, {30'h0, AXI_SLVERR});
		axi(1'b1, REG_COUNT, $urandom());
		check({30'h0, resp}, {30'h0, AXI_SLVERR});
		axi(1'b1, REG_CTRL, 32'h0000_0008);
		wait_state(4'h0);
		repeat (2) @(negedge i_clk);
		check({30'h0, term, lfps}, 32'h0000_0000);
		pulse(0, 4);
		repeat (10) @(negedge i_clk);
		check({28'h0, o_state}, 32'h0000_0000);
		axi(1'b0, REG_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_0020);
		axi(1'b1, REG_CTRL, 32'h0000_0010);
		wait_state(4'h6);
		to_quiet();
		wait_state(4'h4);
		wait_state(4'h3);
		axi(1'b1, REG_CTRL, 32'h0000_0020);
		wait_state(4'h5);
		check({31'h0, warm_tx}, 32'h0000_0001);
		pulse(1, 1);
		to_quiet();
		axi(1'b1, REG_CTRL, 32'h0000_0008);
		wait_state(4'h0);
		axi(1'b1, REG_CTRL, 32'h0000_0010);
		to_quiet();
		found <= 1'b0;
		wait_state(4'h4);
		wait_state(4'h6);
		axi(1'b1, REG_CTRL, 32'h0000_0005);
		vbus <= 1'b0;
		wait_state(4'h0);
		vbus <= 1'b1;
		wait_state(4'h6);
		to_quiet();
		warm_det <= 1'b1;
		wait_state(4'h5);
		warm_det <= 1'b0;
		pulse(1, 1);
		wait_state(4'h6);
		found <= 1'b0;
		axi(1'b1, REG_CTRL, 32'h0000_0006);
		vbus <= 1'b0;
		wait_state(4'h1);
		axi(1'b0, REG_COUNT, 32'h0000_0000);
		check(rd & 32'h0000_0003, 32'h0000_0000);
		vbus <= 1'b1;
		wait_state(4'h6);
		for (k = 1; k < 3; k++) begin
			wait_state(4'h1);
			axi(1'b0, REG_COUNT, 32'h0000_0000);
			check(rd & 32'h0000_0003, 32'(k));
			pulse(0, 4);
			wait_state(4'h6);
		end
		wait_state(4'h2);
		pulse(0, 4);
		repeat (20) @(negedge i_clk);
		check({28'h0, o_state}, 32'h0000_0002);
		pulse(2, 1);
		axi(1'b0, REG_COUNT, 32'h0000_0000);
		check(rd & 32'h0000_0003, 32'h0000_0000);
		vbus <= 1'b0;
		wait_state(4'h1);
		wrap_up();
	end
endmodule

bind ldirx_fsm ldirx_fsm_asserts #(.INACT_CYC(INACT_CYC)) u_asserts (
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_vbus_valid(i_vbus_valid),
	.i_det_done(i_det_done), .i_det_found(i_det_found), .o_det_req(o_det_req),
	.o_term_low_imp(o_term_low_imp), .o_lfps_enable(o_lfps_enable), .o_state(o_state));
`default_nettype wire
